// file: core/cbg_regs.svh
// Constants for the processor board bus and panel glue block
`ifndef CBG_REGS_SVH
`define CBG_REGS_SVH
`define CBG_ROM_WORDS 12'h800
`define CBG_RAM_WORDS 12'h100
`define CBG_ROM_AW 11
`define CBG_RAM_AW 8
`define CBG_ROM_BASE 12'h000
`define CBG_RAM_BASE 12'h800
`define CBG_RATE_W 4
`define CBG_RATE_NONE 4'h0
`define CBG_FLAG_W 4
`define CBG_WAIT_CYCLES 2'h1
`define CBG_RDY_DELAY 4'h4
`define CBG_STOP_BITS 2'h2
`define CBG_PARITY_OFF 1'h1
`define CBG_OSR_ZERO 12'h000
`define CBG_CNT_ZERO 4'h0
`define CBG_CNT_STEP 4'h1
`define CBG_LC_HI 3
`define CBG_LC_LO 2
`define CBG_LC_OFF 2'h0
`define CBG_PORTS 2
`endif

// file: core/cbg_pkg.sv
// Types for the processor board bus and panel glue block
package cbg_pkg;
	typedef enum logic [1:0] {
		CBG_IDLE = 2'b00,
		CBG_WAIT = 2'b01,
		CBG_DONE = 2'b10
	} cbg_wait_e;
	typedef struct packed {
		logic rx_ready;
		logic framing_error;
		logic tx_ready;
	} cbg_uart_s;
	typedef struct packed {
		logic [3:0] rate;
		logic stop_two;
		logic parity_off;
	} cbg_fmt_s;
endpackage : cbg_pkg

// file: core/cbg_glue.sv
// Bus direction, panel memory steering and serial port glue of the processor board
`timescale 1ns/1ps
`default_nettype none
`include "cbg_regs.svh"

// Operation
// RULE1: One wait cycle on each I/O transfer read, device select and transfer control.
// RULE2: Input enable high when processor expects data from an expansion module.
// RULE3: Output enable for processor or extension addresses and for write data.
// RULE4: Switch register read returns zeros or auto-start strap settings.
// RULE5: Panel space maps 2048 words of ROM and 256 words of RAM.
// RULE6: Panel force flag low sends every memory reference to panel memory.
// RULE7: While forcing panel references, drive main memory inhibit.
// RULE8: Main memory inhibit released whenever transfer control is low, for DMA.
// RULE9: On-board panel memory can be disabled, select routed to the bus.
// RULE10: Two independent serial ports, each with up to 15 rates.
// RULE11: Primary port rate comes from four static switches.
// RULE12: Secondary port rate comes from programmable flags.
// RULE13: Secondary transmit ready gated by a supervisory control.
// RULE14: Flags 3 and 4 drive two serial line control outputs.
// RULE15: Primary receive ready delayed so a break interrupts the panel first.
// RULE16: Both ports use no parity and two stop bits.
// RULE17: Framing error on either port raises a panel interrupt request.
// RULE18: Input enable and output enable never high in the same cycle.
module cbg_glue (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic io_transfer_instruction,
	input wire logic device_select_strobe,
	input wire logic transfer_control,
	input wire logic memory_select_strobe,
	input wire logic cpu_read,
	input wire logic cpu_write,
	input wire logic addr_phase,
	input wire logic ext_addr_phase,
	input wire logic onboard_source,
	input wire logic switch_register_read_op,
	input wire logic autostart_sel,
	input wire logic [11:0] autostart_strap,
	input wire logic [11:0] ext_bus_in,
	input wire logic panel_access,
	input wire logic [11:0] cpu_addr,
	input wire logic [11:0] cpu_wdata,
	input wire logic panel_force_flag,
	input wire logic panel_onboard_en,
	input wire logic [`CBG_FLAG_W-1:0] prog_flags,
	input wire logic [`CBG_RATE_W-1:0] rate_switch,
	input wire logic [`CBG_RATE_W-1:0] sec_rate_flags,
	input wire logic sec_tx_permit,
	input wire cbg_pkg::cbg_uart_s uart_pri,
	input wire cbg_pkg::cbg_uart_s uart_sec,
	output logic cpu_wait,
	output logic bus_input_enable,
	output logic bus_output_enable,
	output logic [11:0] cpu_rdata,
	output logic main_memory_inhibit,
	output logic panel_rom_sel,
	output logic panel_ram_sel,
	output logic ext_panel_sel,
	output cbg_pkg::cbg_fmt_s fmt_pri,
	output cbg_pkg::cbg_fmt_s fmt_sec,
	output logic sec_tx_ready,
	output logic pri_rx_ready,
	output logic [1:0] line_ctrl,
	output logic panel_irq
);
	// ****************************************
	// Input synchronisers for switches and straps
	// ****************************************
	logic [`CBG_RATE_W-1:0] sw_s1, sw_s2, sw_s3, rate_pri;
	logic [11:0] st_s1, st_s2, st_s3, strap_q;
	logic [11:0] panel_rom [0:`CBG_ROM_WORDS-1];
	logic [11:0] panel_ram [0:`CBG_RAM_WORDS-1];
	cbg_pkg::cbg_wait_e wait_state, next_wait_state;
	logic [3:0] rdy_cnt;
	logic fe_any;
	logic panel_sel;
	logic force_panel;
	logic [11:0] panel_rdata;

	// ****************************************
	// Panel address decoding
	// ****************************************
	// Addresses above the RAM window select and write nothing, but a read there returns the RAM word at the low 8 address bits
	function automatic logic cbg_in_rom(input logic [11:0] a);
		return a < (`CBG_ROM_BASE + `CBG_ROM_WORDS);
	endfunction : cbg_in_rom

	function automatic logic cbg_in_ram(input logic [11:0] a);
		return (a >= `CBG_RAM_BASE) && (a < (`CBG_RAM_BASE + `CBG_RAM_WORDS));
	endfunction : cbg_in_ram

	// Pins change only once two late stages agree, which rejects a single glitch
	always_ff @(posedge clk) begin
		if (srst) begin
			sw_s1 <= `CBG_RATE_NONE;
			sw_s2 <= `CBG_RATE_NONE;
			sw_s3 <= `CBG_RATE_NONE;
			rate_pri <= `CBG_RATE_NONE;
		end else if (ce) begin
			sw_s1 <= rate_switch;
			sw_s2 <= sw_s1;
			sw_s3 <= sw_s2;
			if (sw_s2 == sw_s3) begin
				rate_pri <= sw_s3; // [RULE11]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_s1 <= `CBG_OSR_ZERO;
			st_s2 <= `CBG_OSR_ZERO;
			st_s3 <= `CBG_OSR_ZERO;
			strap_q <= `CBG_OSR_ZERO;
		end else if (ce) begin
			st_s1 <= autostart_strap;
			st_s2 <= st_s1;
			st_s3 <= st_s2;
			if (st_s2 == st_s3) begin
				strap_q <= st_s3;
			end
		end
	end

	// ****************************************
	// Wait cycle on I/O transfer reads
	// ****************************************
	always_comb begin
		next_wait_state = wait_state;
		case (wait_state)
			cbg_pkg::CBG_IDLE: begin
				if (io_transfer_instruction && device_select_strobe && transfer_control) begin
					next_wait_state = cbg_pkg::CBG_WAIT; // [RULE1]
				end
			end
			cbg_pkg::CBG_WAIT: begin
				next_wait_state = cbg_pkg::CBG_DONE;
			end
			cbg_pkg::CBG_DONE: begin
				if (!(device_select_strobe && transfer_control)) begin
					next_wait_state = cbg_pkg::CBG_IDLE;
				end
			end
			default: begin
				next_wait_state = cbg_pkg::CBG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wait_state <= cbg_pkg::CBG_IDLE;
		end else if (ce) begin
			wait_state <= next_wait_state;
		end
	end

	// Held for exactly the one cycle spent in the wait state
	assign cpu_wait = (wait_state == cbg_pkg::CBG_WAIT); // [RULE1]

	// ****************************************
	// Bus direction control
	// ****************************************
	logic want_in, want_out;
	assign want_out = addr_phase || ext_addr_phase || cpu_write; // [RULE3]
	assign want_in = cpu_read && !onboard_source && !switch_register_read_op; // [RULE2]

	always_ff @(posedge clk) begin
		if (srst) begin
			bus_output_enable <= 1'b0;
		end else if (ce) begin
			bus_output_enable <= want_out; // [RULE3]
		end
	end

	// Output wins if both are asked; a clash on the bus costs more than a lost read
	always_ff @(posedge clk) begin
		if (srst) begin
			bus_input_enable <= 1'b0;
		end else if (ce) begin
			bus_input_enable <= want_in && !want_out; // [RULE18] [RULE2]
		end
	end

	// ****************************************
	// Read data multiplexing
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			cpu_rdata <= `CBG_OSR_ZERO;
		end else if (ce && cpu_read) begin
			if (switch_register_read_op) begin
				cpu_rdata <= autostart_sel ? strap_q : `CBG_OSR_ZERO; // [RULE4]
			end else if (panel_sel && panel_onboard_en) begin
				cpu_rdata <= panel_rdata;
			end else begin
				cpu_rdata <= ext_bus_in;
			end
		end
	end

	// ****************************************
	// Panel memory and main memory inhibit
	// ****************************************
	assign force_panel = !panel_force_flag; // [RULE6]
	assign panel_sel = memory_select_strobe && (panel_access || force_panel); // [RULE6]

	// Inhibit follows transfer control so DMA cycles reach main memory
	always_ff @(posedge clk) begin
		if (srst) begin
			main_memory_inhibit <= 1'b0;
		end else if (ce) begin
			main_memory_inhibit <= force_panel && transfer_control; // [RULE7] [RULE8]
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			panel_rom_sel <= 1'b0;
		end else if (ce) begin
			panel_rom_sel <= panel_sel && panel_onboard_en && cbg_in_rom(cpu_addr); // [RULE5]
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			panel_ram_sel <= 1'b0;
		end else if (ce) begin
			panel_ram_sel <= panel_sel && panel_onboard_en && cbg_in_ram(cpu_addr); // [RULE5]
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ext_panel_sel <= 1'b0;
		end else if (ce) begin
			ext_panel_sel <= panel_sel && !panel_onboard_en; // [RULE9]
		end
	end

	// ****************************************
	// Panel memory storage
	// ****************************************
	// ROM contents are loaded by the firmware image; zero here
	initial begin
		for (int i = 0; i < `CBG_ROM_WORDS; i++) begin
			panel_rom[i] = `CBG_OSR_ZERO;
		end
	end

	always_ff @(posedge clk) begin
		if (ce && panel_sel && panel_onboard_en && cpu_write && cbg_in_ram(cpu_addr)) begin
			panel_ram[cpu_addr[`CBG_RAM_AW-1:0]] <= cpu_wdata; // [RULE5]
		end
	end

	assign panel_rdata = cbg_in_rom(cpu_addr) ? panel_rom[cpu_addr[`CBG_ROM_AW-1:0]]
		: panel_ram[cpu_addr[`CBG_RAM_AW-1:0]];

	// ****************************************
	// Serial port control
	// ****************************************
	// Both ports share one fixed character format; only the rate source differs
	for (genvar p = 0; p < `CBG_PORTS; p++) begin : g_port
		logic [`CBG_RATE_W-1:0] sel;
		cbg_pkg::cbg_fmt_s q;
		// Port 0 follows the switches, port 1 follows software
		assign sel = (p == 0) ? rate_pri : sec_rate_flags; // [RULE11] [RULE12]
		always_ff @(posedge clk) begin
			if (srst) begin
				q <= '0;
			end else if (ce) begin
				q.rate <= sel; // [RULE10]
				q.stop_two <= (`CBG_STOP_BITS == 2'h2); // [RULE16]
				q.parity_off <= `CBG_PARITY_OFF; // [RULE16]
			end
		end
	end : g_port

	assign fmt_pri = g_port[0].q;
	assign fmt_sec = g_port[1].q;

	// ****************************************
	// Line control outputs
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			line_ctrl <= `CBG_LC_OFF;
		end else if (ce) begin
			line_ctrl <= prog_flags[`CBG_LC_HI:`CBG_LC_LO]; // [RULE14]
		end
	end

	// ****************************************
	// Secondary transmit gating
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			sec_tx_ready <= 1'b0;
		end else if (ce) begin
			sec_tx_ready <= uart_sec.tx_ready && sec_tx_permit; // [RULE13]
		end
	end

	// ****************************************
	// Panel interrupt
	// ****************************************
	assign fe_any = uart_pri.framing_error || uart_sec.framing_error;

	always_ff @(posedge clk) begin
		if (srst) begin
			panel_irq <= 1'b0;
		end else if (ce) begin
			panel_irq <= fe_any; // [RULE17] [RULE15]
		end
	end

	// ****************************************
	// Primary receive ready delay
	// ****************************************
	// Delay lets a break trap to the panel before programs see the character
	always_ff @(posedge clk) begin
		if (srst) begin
			rdy_cnt <= `CBG_CNT_ZERO;
		end else if (ce) begin
			if (!uart_pri.rx_ready) begin
				rdy_cnt <= `CBG_CNT_ZERO;
			end else if (rdy_cnt != `CBG_RDY_DELAY) begin
				rdy_cnt <= rdy_cnt + `CBG_CNT_STEP;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pri_rx_ready <= 1'b0;
		end else if (ce) begin
			pri_rx_ready <= uart_pri.rx_ready && (rdy_cnt == `CBG_RDY_DELAY); // [RULE15]
		end
	end
endmodule : cbg_glue
`default_nettype wire

// file: verification/cbg_bus_peer.sv
// Expansion side model: serial status and a released data bus
`timescale 1ns/1ps
`default_nettype none
module cbg_bus_peer (
	input wire logic clk,
	input wire logic rx,
	input wire logic fe_p,
	input wire logic fe_s,
	input wire logic tx_s,
	output logic [11:0] ext_bus_in,
	output cbg_pkg::cbg_uart_s uart_pri,
	output cbg_pkg::cbg_uart_s uart_sec
);
	// Released lines toggle so a stale value never reads as valid
	logic [11:0] pat = 12'h5a3;
	always @(posedge clk) begin
		pat <= ~pat;
	end
	assign ext_bus_in = pat;
	assign uart_pri = '{rx_ready: rx, framing_error: fe_p, tx_ready: 1'h1};
	assign uart_sec = '{rx_ready: 1'h0, framing_error: fe_s, tx_ready: tx_s};
endmodule : cbg_bus_peer
`default_nettype wire

// file: verification/cbg_glue_chk.sv
// Port checker for the board glue block
`timescale 1ns/1ps
`default_nettype none
module cbg_glue_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic device_select_strobe,
	input wire logic transfer_control,
	input wire logic memory_select_strobe,
	input wire logic addr_phase,
	input wire logic switch_register_read_op,
	input wire logic panel_force_flag,
	input wire cbg_pkg::cbg_uart_s uart_pri,
	input wire cbg_pkg::cbg_uart_s uart_sec,
	input wire logic cpu_wait,
	input wire logic bus_input_enable,
	input wire logic bus_output_enable,
	input wire logic main_memory_inhibit,
	input wire logic sec_tx_permit,
	input wire logic sec_tx_ready,
	input wire logic panel_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst || !ce);
	a_wait_one_cycle: assert property (cpu_wait |=> !cpu_wait) else $error("wait longer than one cycle");
	a_wait_has_cause: assert property (cpu_wait |-> $past(device_select_strobe) && $past(transfer_control))
		else $error("wait without select");
	a_no_bus_clash: assert property (!(bus_input_enable && bus_output_enable)) else $error("both enables");
	a_switch_no_in: assert property (switch_register_read_op |=> !bus_input_enable) else $error("osr input");
	a_addr_drives_out: assert property (addr_phase |=> bus_output_enable) else $error("no out enable");
	a_force_inhibit: assert property (!panel_force_flag && memory_select_strobe && transfer_control
		|=> main_memory_inhibit) else $error("inhibit missing");
	a_dma_released: assert property (!transfer_control |=> !main_memory_inhibit) else $error("inhibit in dma");
	a_break_irq: assert property (uart_pri.framing_error || uart_sec.framing_error |=> panel_irq)
		else $error("no panel irq");
	a_hold_sec_tx: assert property (!sec_tx_permit |=> !sec_tx_ready) else $error("tx not held");
endmodule : cbg_glue_chk
bind cbg_glue cbg_glue_chk chk (.*);
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the board glue block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 0, srst = 1, ce = 1, io_transfer_instruction = 0, device_select_strobe = 0, transfer_control = 0;
	logic memory_select_strobe = 0, cpu_read = 0, cpu_write = 0, addr_phase = 0, ext_addr_phase = 0;
	logic onboard_source = 0, switch_register_read_op = 0, autostart_sel = 0, panel_access = 0;
	logic panel_force_flag = 1, panel_onboard_en = 1, sec_tx_permit = 0, rx = 0, fe_p = 0, fe_s = 0, tx_s = 0;
	logic [11:0] autostart_strap = 12'h000, cpu_addr = 12'h000, cpu_wdata = 12'h000, ext_bus_in, cpu_rdata;
	logic [3:0] prog_flags = 4'h0, rate_switch = 4'h0, sec_rate_flags = 4'h0;
	cbg_pkg::cbg_uart_s uart_pri, uart_sec;
	cbg_pkg::cbg_fmt_s fmt_pri, fmt_sec;
	logic cpu_wait, bus_input_enable, bus_output_enable, main_memory_inhibit, panel_rom_sel, panel_ram_sel;
	logic ext_panel_sel, sec_tx_ready, pri_rx_ready, panel_irq;
	logic [1:0] line_ctrl;
	int n_errors = 0, checks_done = 0, cyc = 0;
	always #5 clk = ~clk;
	cbg_glue dut (.*);
	cbg_bus_peer peer (.clk(clk), .rx(rx), .fe_p(fe_p), .fe_s(fe_s), .tx_s(tx_s), .ext_bus_in(ext_bus_in),
		.uart_pri(uart_pri), .uart_sec(uart_sec));
	task w(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : w
	task ck(logic [11:0] g, logic [11:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : ck
	task results;
		if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	// Run is about 57 cycles; the ceiling only catches a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			results;
		end
	end
	task t_wait;
		@(posedge clk);
		io_transfer_instruction <= 1;
		device_select_strobe <= 1;
		transfer_control <= 1;
		w(1);
		ck(cpu_wait, 1'h1);
		w(1);
		ck(cpu_wait, 1'h0);
		@(posedge clk);
		io_transfer_instruction <= 0;
		device_select_strobe <= 0;
	endtask : t_wait
	task t_panel;
		@(posedge clk);
		panel_force_flag <= 0;
		memory_select_strobe <= 1;
		cpu_addr <= 12'h7ff;
		w(1);
		ck({main_memory_inhibit, panel_rom_sel, panel_ram_sel}, 3'h6);
		@(posedge clk);
		cpu_addr <= 12'h8ff;
		w(1);
		ck({panel_rom_sel, panel_ram_sel}, 2'h1);
		@(posedge clk);
		panel_onboard_en <= 0;
		w(1);
		ck({ext_panel_sel, panel_rom_sel, panel_ram_sel}, 3'h4);
		@(posedge clk);
		transfer_control <= 0;
		w(1);
		ck(main_memory_inhibit, 1'h0);
		@(posedge clk);
		panel_force_flag <= 1;
		memory_select_strobe <= 0;
		panel_onboard_en <= 1;
	endtask : t_panel
	task t_osr;
		@(posedge clk);
		switch_register_read_op <= 1;
		cpu_read <= 1;
		autostart_sel <= 1;
		autostart_strap <= 12'ha5c;
		w(6);
		ck(cpu_rdata, 12'ha5c);
		ck(bus_input_enable, 1'h0);
		@(posedge clk);
		autostart_sel <= 0;
		w(2);
		ck(cpu_rdata, 12'h000);
		@(posedge clk);
		switch_register_read_op <= 0;
		w(1);
		ck({bus_input_enable, bus_output_enable}, 2'h2);
		ck(cpu_rdata, ~ext_bus_in);
		@(posedge clk);
		cpu_write <= 1;
		cpu_wdata <= 12'h3c3;
		ext_addr_phase <= 1;
		addr_phase <= 1;
		w(1);
		ck({bus_input_enable, bus_output_enable}, 2'h1);
		@(posedge clk);
		cpu_read <= 0;
		cpu_write <= 0;
		addr_phase <= 0;
		ext_addr_phase <= 0;
		onboard_source <= 1;
	endtask : t_osr
	task t_ram;
		@(posedge clk);
		panel_access <= 1;
		memory_select_strobe <= 1;
		cpu_write <= 1;
		cpu_addr <= 12'h810;
		cpu_wdata <= 12'h3c3;
		@(posedge clk);
		cpu_addr <= 12'h910;
		cpu_wdata <= 12'h0f0;
		w(1);
		ck({panel_rom_sel, panel_ram_sel}, 2'h0);
		@(posedge clk);
		cpu_write <= 0;
		cpu_read <= 1;
		cpu_addr <= 12'h810;
		w(1);
		ck({panel_rom_sel, panel_ram_sel}, 2'h1);
		ck(cpu_rdata, 12'h3c3);
		@(posedge clk);
		panel_access <= 0;
		memory_select_strobe <= 0;
		cpu_read <= 0;
	endtask : t_ram
	task t_freeze;
		@(posedge clk);
		ce <= 0;
		sec_rate_flags <= 4'h9;
		w(2);
		ck(fmt_sec.rate, 4'h6);
		@(posedge clk);
		ce <= 1;
		w(2);
		ck(fmt_sec.rate, 4'h9);
	endtask : t_freeze
	task t_serial;
		@(posedge clk);
		rate_switch <= 4'hf;
		sec_rate_flags <= 4'h6;
		prog_flags <= 4'h8;
		tx_s <= 1;
		rx <= 1;
		w(3);
		ck(pri_rx_ready, 1'h0);
		ck(sec_tx_ready, 1'h0);
		@(posedge clk);
		sec_tx_permit <= 1;
		fe_s <= 1;
		w(4);
		ck({pri_rx_ready, sec_tx_ready, panel_irq}, 3'h7);
		ck({fmt_pri.rate, fmt_sec.rate}, 8'hf6);
		ck(line_ctrl, 2'h2);
	endtask : t_serial
	initial begin
		repeat (6) @(posedge clk);
		srst <= 0;
		w(2);
		ck({fmt_pri.stop_two, fmt_pri.parity_off, fmt_sec.stop_two, fmt_sec.parity_off}, 4'hf);
		t_wait();
		t_panel();
		t_osr();
		t_ram();
		t_serial();
		t_freeze();
		results();
	end
endmodule : tb
`default_nettype wire
